// ### rtl/ecfm_freq.sv
// Encoder pulse rate monitor against a computed maximum
`timescale 1ns/1ns
module ecfm_freq
	import ecfm_pkg::*;
#(
	parameter int WIN = WIN_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic step,
	input wire logic [15:0] resolution,
	input wire logic [15:0] max_speed,
	output logic win_tick,
	output logic over_rate
);
	logic [31:0] win_q;
	logic [31:0] cnt_q;
	logic [31:0] max_q;
	logic [31:0] lim_q;
	logic [31:0] prod;

	assign prod = resolution * max_speed;
	assign win_tick = (win_q == 32'(WIN - 1));
	// Reaching 1.5 x max within one window
	assign over_rate = (cnt_q + {31'h0, step}) >= lim_q && lim_q != 32'h0;

	// Max count per window follows settings every clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			max_q <= 32'h0000_0000;
			lim_q <= 32'h0000_0000;
		end else begin
			max_q <= (prod + 32'(RPM_WIN_DIV - 1)) / 32'(RPM_WIN_DIV);
			lim_q <= max_q + (max_q >> 1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_q <= 32'h0000_0000;
			cnt_q <= 32'h0000_0000;
		end else if (win_tick) begin
			win_q <= 32'h0000_0000;
			cnt_q <= 32'h0000_0000;
		end else begin
			win_q <= win_q + 32'h0000_0001;
			cnt_q <= cnt_q + {31'h0, step};
		end
	end
endmodule // ecfm_freq

// ### rtl/ecfm_pkg.sv
// Shared constants of the encoder counting fault monitor
package ecfm_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int WIN_NS = 1000000;
	localparam int WIN_CYC = (WIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SOFTSTART_MS = 3000;
	localparam int RPM_WIN_DIV = 60000;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ENC_CFG = 8'h04;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h08;
	localparam logic [7:0] OFS_FOLLOW_THR = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_PWR_CAUSE = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] OFS_POSITION = 8'h20;
	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int CTRL_FAULT_RST = 0;
	localparam int CTRL_HALL = 1;
	localparam int CTRL_SINCOS = 2;
	localparam int CTRL_SPEED_MODE = 3;
	localparam int CTRL_HV = 4;
	localparam int CFG_RES_LSB = 0;
	localparam int CFG_PITCH_LSB = 16;
	localparam logic [3:0] PITCH_OFF = 4'h0;
	localparam logic [3:0] PITCH_SINGLE = 4'hF;
	localparam logic [4:0] CTRL_RST_VAL = 5'h00;
	localparam logic [15:0] RES_RST_VAL = 16'h0000;
	localparam logic [3:0] PITCH_RST_VAL = 4'h0;
	localparam logic [15:0] SPEED_RST_VAL = 16'h0000;
	localparam logic [15:0] THR_RST_VAL = 16'hFFFF;
	// Power stage cause bits
	localparam int PS_OVERVOLT = 0;
	localparam int PS_OVERTEMP = 5;
	localparam int PS_W = 9;
	// Status / interrupt bits
	localparam int ST_COUNT = 0;
	localparam int ST_FREQ = 1;
	localparam int ST_FEEDBACK = 2;
	localparam int ST_POWER = 3;
	localparam int ST_FOLLOW = 4;
	localparam int ST_SUPPLY = 5;
	localparam int ST_PHASE_OK = 6;
	localparam int EV_W = 6;
endpackage

// ### rtl/ecfm_quad.sv
// Quadrature decoder with x4 edge counting and position register
`timescale 1ns/1ns
module ecfm_quad
	import ecfm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic step,
	output logic dir_up,
	output logic [31:0] position
);
	logic [1:0] ab_q;
	logic [1:0] ab_d;
	logic [31:0] pos_q;

	assign ab_d = {enc_a, enc_b};
	// Gray step forward: 00-01-11-10; a double jump is ignored
	assign step = (ab_d != ab_q) && ((ab_d ^ ab_q) != 2'h3);
	assign dir_up = (ab_q[1] ^ ab_d[0]);
	assign position = pos_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ab_q <= 2'h0;
		end else begin
			ab_q <= ab_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos_q <= 32'h0000_0000;
		end else if (step) begin
			pos_q <= dir_up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
		end
	end
endmodule // ecfm_quad

// ### rtl/ecfm_top.sv
// Encoder counting, power stage, supply and following error supervision
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Operation
// RL1 - Counting enabled: edges between markers must equal resolution times pitch.
// RL2 - Sin/cos encoders use the reference signal as the marker.
// RL3 - Pitch zero disables marker channel and counting check.
// RL4 - Pitch fifteen: position at every marker must match previous capture.
// RL5 - Counting disabled: fault when pulse rate reaches 1.5 times maximum.
// RL6 - Maximum encoder rate recomputed from resolution and maximum speed.
// RL7 - Without hall sensors, counting fault invalidates commutation phase.
// RL8 - Without hall sensors, feedback fault invalidates commutation phase.
// RL9 - Supply low while aux on without power; clears after soft start.
// RL10 - Power stage fault is OR of all power stage causes.
// RL11 - Individual power stage cause readable over the register bus.
// RL12 - Speed mode: following fault when speed error exceeds threshold.
// RL13 - Counting, feedback, power faults latch until explicit fault reset.
module ecfm_top
	import ecfm_pkg::*;
#(
	parameter int WIN = WIN_CYC,
	parameter int SOFT_MS = SOFTSTART_MS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_z,
	input wire logic enc_r,
	input wire logic feedback_loss,
	input wire logic [PS_W-1:0] pwr_src,
	input wire logic aux_on,
	input wire logic bus_present,
	input wire logic signed [15:0] speed_err,
	input wire logic phasing_done,
	output logic supply_low_fault,
	output logic fault_out,
	output logic phase_valid,
	output logic enable_ok,
	output logic irq
);
	// ------------------------------------------------------------
	// Registers and nets
	// ------------------------------------------------------------
	logic [4:0] ctrl_q;
	logic [15:0] res_q;
	logic [3:0] pitch_q;
	logic [15:0] speed_q;
	logic [15:0] thr_q;
	logic [EV_W-1:0] irq_stat_q;
	logic [EV_W-1:0] irq_mask_q;
	logic [31:0] prdata_q;
	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic fault_rst;
	logic step;
	logic dir_up;
	logic [31:0] position;
	logic win_tick;
	logic over_rate;
	logic mark_sel;
	logic mark_q;
	logic mark_ev;
	logic armed_q;
	logic [31:0] edge_cnt_q;
	logic [31:0] cap_pos_q;
	logic [19:0] expected;
	logic count_err;
	logic count_flt_q;
	logic freq_flt_q;
	logic fb_flt_q;
	logic [PS_W-1:0] ps_cause_q;
	logic [PS_W-1:0] ps_live;
	logic ps_any;
	logic follow_flt_q;
	logic [15:0] err_abs;
	logic supply_low_q;
	logic [15:0] soft_q;
	logic phase_ok_q;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] lat_prev_q;
	logic [EV_W-1:0] lat_now;
	logic [31:0] status_word;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	ecfm_quad u_quad (
		.clk(clk),
		.rst_n(rst_n),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.step(step),
		.dir_up(dir_up),
		.position(position)
	);

	// RL6 rate from settings
	ecfm_freq #(
		.WIN(WIN)
	) u_freq (
		.clk(clk),
		.rst_n(rst_n),
		.step(step),
		.resolution(res_q),
		.max_speed(speed_q),
		.win_tick(win_tick),
		.over_rate(over_rate)
	);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign fault_rst = wr_en && addr_ok && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RST];

	always_comb begin
		unique case (paddr)
			OFS_CTRL, OFS_ENC_CFG, OFS_MAX_SPEED, OFS_FOLLOW_THR, OFS_STATUS,
			OFS_PWR_CAUSE, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_POSITION: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	// Unmapped addresses answer with an error
	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST_VAL;
			res_q <= RES_RST_VAL;
			pitch_q <= PITCH_RST_VAL;
			speed_q <= SPEED_RST_VAL;
			thr_q <= THR_RST_VAL;
			irq_mask_q <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				OFS_CTRL: ctrl_q <= {pwdata[4:1], 1'b0};
				OFS_ENC_CFG: begin
					res_q <= pwdata[CFG_RES_LSB +: 16];
					pitch_q <= pwdata[CFG_PITCH_LSB +: 4];
				end
				OFS_MAX_SPEED: speed_q <= pwdata[15:0];
				OFS_FOLLOW_THR: thr_q <= pwdata[15:0];
				OFS_IRQ_MASK: irq_mask_q <= pwdata[EV_W-1:0];
				default: ;
			endcase
		end
	end

	assign status_word = {25'h0, phase_ok_q, supply_low_q, follow_flt_q, ps_any,
		fb_flt_q, freq_flt_q, count_flt_q};

	// Read data captured in setup, stable through access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (paddr)
				OFS_CTRL: prdata_q <= {27'h0, ctrl_q};
				OFS_ENC_CFG: prdata_q <= {12'h0, pitch_q, res_q};
				OFS_MAX_SPEED: prdata_q <= {16'h0, speed_q};
				OFS_FOLLOW_THR: prdata_q <= {16'h0, thr_q};
				OFS_STATUS: prdata_q <= status_word;
				// RL11 cause readback
				OFS_PWR_CAUSE: prdata_q <= {23'h0, ps_cause_q};
				OFS_IRQ_STAT: prdata_q <= {26'h0, irq_stat_q};
				OFS_IRQ_MASK: prdata_q <= {26'h0, irq_mask_q};
				OFS_POSITION: prdata_q <= position;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Marker counting check
	// ------------------------------------------------------------
	// RL2 reference as marker
	assign mark_sel = ctrl_q[CTRL_SINCOS] ? enc_r : enc_z;
	assign mark_ev = mark_sel && !mark_q;
	assign expected = res_q * {16'h0, pitch_q};

	// RL1 count mismatch
	always_comb begin
		count_err = 1'b0;
		if (mark_ev && armed_q && pitch_q != PITCH_OFF) begin
			if (pitch_q == PITCH_SINGLE) begin
				// RL4 drift on single marker
				count_err = (position != cap_pos_q);
			end else begin
				count_err = (edge_cnt_q != {12'h0, expected});
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mark_q <= 1'b0;
		end else begin
			mark_q <= mark_sel;
		end
	end

	// First marker only arms; count is unsigned edge total
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
			edge_cnt_q <= 32'h0000_0000;
			cap_pos_q <= 32'h0000_0000;
		end else if (pitch_q == PITCH_OFF) begin
			// RL3 marker channel off
			armed_q <= 1'b0;
			edge_cnt_q <= 32'h0000_0000;
		end else if (mark_ev) begin
			armed_q <= 1'b1;
			edge_cnt_q <= {31'h0, step};
			cap_pos_q <= position;
		end else if (step && edge_cnt_q != 32'hFFFF_FFFF) begin
			edge_cnt_q <= edge_cnt_q + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// Latched faults
	// ------------------------------------------------------------
	// RL13 latch until reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_flt_q <= 1'b0;
		end else if (count_err) begin
			count_flt_q <= 1'b1;
		end else if (fault_rst) begin
			count_flt_q <= 1'b0;
		end
	end

	// RL5 rate check when counting is off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			freq_flt_q <= 1'b0;
		end else if (pitch_q == PITCH_OFF && over_rate) begin
			freq_flt_q <= 1'b1;
		end else if (fault_rst) begin
			freq_flt_q <= 1'b0;
		end
	end

	// RL13 feedback latched
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fb_flt_q <= 1'b0;
		end else if (feedback_loss) begin
			fb_flt_q <= 1'b1;
		end else if (fault_rst) begin
			fb_flt_q <= 1'b0;
		end
	end

	// Overtemperature source exists only on the high-voltage variant
	assign ps_live = pwr_src & ~(PS_W'(!ctrl_q[CTRL_HV]) << PS_OVERTEMP);

	// RL13 causes held until reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ps_cause_q <= '0;
		end else if (fault_rst) begin
			ps_cause_q <= ps_live;
		end else begin
			ps_cause_q <= ps_cause_q | ps_live;
		end
	end
	// RL10 grouped stage fault
	assign ps_any = |ps_cause_q;

	// RL12 speed following error
	assign err_abs = speed_err[15] ? 16'(-speed_err) : speed_err;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			follow_flt_q <= 1'b0;
		end else if (ctrl_q[CTRL_SPEED_MODE] && err_abs > thr_q) begin
			follow_flt_q <= 1'b1;
		end else if (fault_rst) begin
			follow_flt_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Supply low, not latched
	// ------------------------------------------------------------
	// RL9 soft start delay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			supply_low_q <= 1'b1;
			soft_q <= 16'h0000;
		end else if (aux_on && !bus_present) begin
			supply_low_q <= 1'b1;
			soft_q <= 16'h0000;
		end else if (soft_q == 16'(SOFT_MS)) begin
			supply_low_q <= 1'b0;
		end else if (win_tick) begin
			soft_q <= soft_q + 16'h0001;
		end
	end
	assign supply_low_fault = supply_low_q;

	// ------------------------------------------------------------
	// Commutation phase validity
	// ------------------------------------------------------------
	// Raising fault wins over a same-cycle phasing completion
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_ok_q <= 1'b0;
		end else if (!ctrl_q[CTRL_HALL] && (count_err || feedback_loss)) begin
			// RL7 RL8 rephase needed
			phase_ok_q <= 1'b0;
		end else if (phasing_done || ctrl_q[CTRL_HALL]) begin
			phase_ok_q <= 1'b1;
		end
	end
	assign phase_valid = phase_ok_q;

	assign fault_out = count_flt_q | freq_flt_q | fb_flt_q | ps_any | follow_flt_q;
	// RL7 enable needs phasing
	assign enable_ok = phase_ok_q && !fault_out && !supply_low_q;

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	assign lat_now = {supply_low_q, follow_flt_q, ps_any, fb_flt_q, freq_flt_q, count_flt_q};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lat_prev_q <= '0;
		end else begin
			lat_prev_q <= lat_now;
		end
	end
	assign ev = lat_now & ~lat_prev_q;

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (wr_en && paddr == OFS_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[EV_W-1:0]) | ev;
		end else begin
			irq_stat_q <= irq_stat_q | ev;
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);
endmodule // ecfm_top

// ### verification/ecfm_assertions.sv
// Port-level checks of the encoder counting fault monitor
`timescale 1ns/1ns
module ecfm_assertions
	import ecfm_pkg::*;
#(
	parameter int WIN = WIN_CYC,
	parameter int SOFT_MS = SOFTSTART_MS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PS_W-1:0] pwr_src,
	input wire logic aux_on,
	input wire logic bus_present,
	input wire logic phasing_done,
	input wire logic supply_low_fault,
	input wire logic fault_out,
	input wire logic phase_valid,
	input wire logic enable_ok
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic acc;
	logic clr_wr;
	int pres_q;
	assign acc = psel && penable && paddr[1:0] == 2'h0;
	assign clr_wr = acc && pwrite && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RST];
	// Soft start may begin mid window, so one window is forgiven
	always_ff @(posedge clk) begin
		if (!bus_present || !rst_n) begin
			pres_q <= 0;
		end else if (pres_q < 100000) begin
			pres_q <= pres_q + 1;
		end
	end
	sequence s_no_power;
		aux_on && !bus_present;
	endsequence
	sequence s_clear_req;
		$past(clr_wr, 1) || $past(clr_wr, 2);
	endsequence
	a_ready_always: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (acc |-> pslverr == (paddr > OFS_POSITION))
		else $error("pslverr wrong");
	a_unmapped_zero: assert property (acc && !pwrite && paddr > OFS_POSITION |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_power_group: assert property ($rose(pwr_src[PS_OVERVOLT]) |-> ##[1:3] fault_out)
		else $error("power fault missing");
	a_fault_latch: assert property ($fell(fault_out) |-> s_clear_req)
		else $error("fault dropped without reset");
	a_supply_set: assert property (s_no_power |-> ##[0:2] supply_low_fault)
		else $error("supply low missing");
	a_supply_wait: assert property ($fell(supply_low_fault) |-> pres_q >= (SOFT_MS - 1) * WIN)
		else $error("supply low cleared early");
	a_enable_gate: assert property (enable_ok |-> phase_valid && !fault_out && !supply_low_fault)
		else $error("enable while not ready");
	a_phasing_back: assert property (phasing_done && !fault_out |-> ##[1:2] phase_valid)
		else $error("phase not restored");
	a_phase_loss: assert property ($fell(phase_valid) |-> ##[0:2] fault_out)
		else $error("phase lost without fault");
endmodule // ecfm_assertions

// ### verification/ecfm_enc_model.sv
// Behavioural quadrature encoder with marker and reference outputs
`timescale 1ns/1ns
module ecfm_enc_model (
	input wire logic clk,
	output logic enc_a,
	output logic enc_b,
	output logic enc_z,
	output logic enc_r
);
	// ------------------------------------------------------------
	// Gray phase, one line change per step
	// ------------------------------------------------------------
	logic [1:0] ph_q = 2'h0;
	assign enc_a = ph_q[1];
	assign enc_b = ph_q[1] ^ ph_q[0];
	initial begin
		enc_z = 1'b0;
		enc_r = 1'b0;
	end
	task automatic move(input int n, input int gap);
		for (int i = 0; i < (n < 0 ? -n : n); i++) begin
			repeat (gap) @(posedge clk);
			ph_q <= (n < 0) ? ph_q - 2'h1 : ph_q + 2'h1;
		end
	endtask
	task automatic mark(input logic use_ref);
		@(posedge clk);
		enc_z <= !use_ref;
		enc_r <= use_ref;
		repeat (2) @(posedge clk);
		enc_z <= 1'b0;
		enc_r <= 1'b0;
	endtask
endmodule // ecfm_enc_model

// ### verification/ecfm_top_tb.sv
// Self-checking bench of the encoder counting fault monitor
`timescale 1ns/1ns
module ecfm_top_tb
	import ecfm_pkg::*;
;
	localparam int W = 100;
	localparam int SMS = 3;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, ex;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic enc_a, enc_b, enc_z, enc_r, feedback_loss, aux_on, bus_present, phasing_done;
	logic [PS_W-1:0] pwr_src;
	logic signed [15:0] speed_err;
	logic supply_low_fault, fault_out, phase_valid, enable_ok, irq;
	logic [4:0] ctrl;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int res, pit, mx, lim, b;
	int q[$];
	int spd[3] = '{1000, 1000, 5000};
	int gap[3] = '{10, 2, 2};
	int ev[3] = '{100, 101, 500};
	logic [7:0] ro[5] = '{OFS_CTRL, OFS_ENC_CFG, OFS_MAX_SPEED, OFS_FOLLOW_THR, OFS_IRQ_MASK};
	logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0};
	ecfm_top #(.WIN(W), .SOFT_MS(SMS)) dut_u (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .enc_r(enc_r),
		.feedback_loss(feedback_loss), .pwr_src(pwr_src), .aux_on(aux_on),
		.bus_present(bus_present), .speed_err(speed_err), .phasing_done(phasing_done),
		.supply_low_fault(supply_low_fault), .fault_out(fault_out),
		.phase_valid(phase_valid), .enable_ok(enable_ok), .irq(irq)
	);
	ecfm_enc_model enc_u (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .enc_r(enc_r));
	// ------------------------------------------------------------
	// Clock, timeout, tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cw(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cb(input logic g, input logic e);
		cw({31'h0, g}, {31'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Holds the whole request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic st(input int bit_no, input logic e);
		apb(1'b0, OFS_STATUS, 32'h0);
		cb(rd[bit_no], e);
	endtask
	task automatic frst();
		apb(1'b1, OFS_CTRL, {27'h0, ctrl} | 32'h1);
	endtask
	// Pitch passes through zero so the next marker only arms
	task automatic cfg(input int r, input int p);
		apb(1'b1, OFS_ENC_CFG, 32'(r));
		apb(1'b1, OFS_ENC_CFG, 32'(p << CFG_PITCH_LSB | r));
	endtask
	task automatic phase();
		@(posedge clk) phasing_done <= 1'b1;
		@(posedge clk) phasing_done <= 1'b0;
		wt(3);
		cb(phase_valid, 1'b1);
	endtask
	function automatic bit cnt_exp(input int n, input int r, input int p);
		return (p == 0) ? 1'b0 : (p == 15) ? (n != 0) : (n != r * p);
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(99410));
		{psel, penable, pwrite, feedback_loss, phasing_done, bus_present} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pwr_src = '0;
		speed_err = 16'sh0;
		aux_on = 1'b1;
		rst_n = 1'b0;
		ctrl = 5'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ro[i], 32'h0);
			cw(rd, rv[i]);
		end
		apb(1'b0, 8'h24, 32'h0);
		cw(rd, 32'h0);
		cb(er, 1'b1);
		for (int i = 0; i < 2; i++) begin
			cb(supply_low_fault, 1'b1);
			bus_present <= 1'b1;
			wt(150);
			cb(supply_low_fault, 1'b1);
			wt(250);
			cb(supply_low_fault, 1'b0);
			bus_present <= 1'b0;
			wt(3);
		end
		bus_present <= 1'b1;
		wt(400);
		for (int s = 0; s < 2; s++) begin
			ctrl = 5'(s) << CTRL_SINCOS;
			apb(1'b1, OFS_CTRL, {27'h0, ctrl});
			res = 2 + $urandom % 5;
			pit = 1 + $urandom % 2;
			cfg(res, pit);
			phase();
			q = '{res * pit, res * pit + 1, res * pit - 1};
			enc_u.mark(s != 0);
			foreach (q[j]) begin
				enc_u.move(q[j], 2);
				enc_u.mark(s != 0);
				st(ST_COUNT, cnt_exp(q[j], res, pit));
				if (cnt_exp(q[j], res, pit)) cb(phase_valid, 1'b0);
				frst();
				phase();
			end
		end
		ctrl = 5'h01 << CTRL_HALL;
		apb(1'b1, OFS_CTRL, {27'h0, ctrl});
		cfg(4, 1);
		enc_u.mark(1'b0);
		enc_u.move(5, 2);
		enc_u.mark(1'b0);
		st(ST_COUNT, 1'b1);
		cb(phase_valid, 1'b1);
		frst();
		ctrl = 5'h00;
		apb(1'b1, OFS_CTRL, 32'h0);
		cfg(4, 0);
		enc_u.mark(1'b0);
		enc_u.move(7, 2);
		enc_u.mark(1'b0);
		st(ST_COUNT, 1'b0);
		cfg(4, 15);
		enc_u.mark(1'b0);
		enc_u.move(3, 2);
		enc_u.move(-3, 2);
		enc_u.mark(1'b0);
		st(ST_COUNT, cnt_exp(0, 4, 15));
		enc_u.move(2, 2);
		enc_u.mark(1'b0);
		st(ST_COUNT, cnt_exp(2, 4, 15));
		frst();
		cfg(600, 0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_MAX_SPEED, 32'(spd[i]));
			mx = (600 * spd[i] + 59999) / 60000;
			lim = mx + mx / 2;
			enc_u.move((i % 2) ? -3 * W / gap[i] : 3 * W / gap[i], gap[i]);
			st(ST_FREQ, W / gap[i] >= lim);
			// Window count must drain first, else the rate fault re-sets
			wt(W);
			frst();
		end
		for (int i = 0; i < 2; i++) begin
			phase();
			ex = 1'(i);
			@(posedge clk) feedback_loss <= ex;
			@(posedge clk) feedback_loss <= 1'b0;
			wt(3);
			st(ST_FEEDBACK, ex);
			cb(phase_valid, !ex);
			cb(enable_ok, !ex);
			frst();
			st(ST_FEEDBACK, 1'b0);
		end
		phase();
		apb(1'b1, OFS_IRQ_MASK, 32'h1 << ST_POWER);
		for (int k = 0; k <= PS_W; k++) begin
			b = (k == PS_W) ? PS_OVERTEMP : k;
			ctrl = (k == PS_W) ? (5'h01 << CTRL_HV) : 5'h00;
			ex = (b != PS_OVERTEMP) || (k == PS_W);
			apb(1'b1, OFS_CTRL, {27'h0, ctrl});
			@(posedge clk) pwr_src <= PS_W'(1) << b;
			@(posedge clk) pwr_src <= '0;
			wt(3);
			cb(fault_out, ex);
			cb(irq, ex);
			if (ex) apb(1'b0, OFS_PWR_CAUSE, 32'h0);
			if (ex) cw(rd, 32'h1 << b);
			if (k == 0) begin
				apb(1'b1, OFS_IRQ_MASK, 32'h0);
				wt(2);
				cb(irq, 1'b0);
				apb(1'b1, OFS_IRQ_MASK, 32'h1 << ST_POWER);
			end
			frst();
			apb(1'b1, OFS_IRQ_STAT, 32'h3F);
			wt(2);
			cb(irq, 1'b0);
		end
		cb(enable_ok, 1'b1);
		apb(1'b1, OFS_FOLLOW_THR, 32'h64);
		for (int i = 0; i < 3; i++) begin
			ctrl = (i < 2) ? (5'h01 << CTRL_SPEED_MODE) : 5'h00;
			apb(1'b1, OFS_CTRL, {27'h0, ctrl});
			speed_err <= 16'(ev[i]);
			aux_on <= 1'($urandom % 2);
			wt(3);
			st(ST_FOLLOW, i < 2 && ev[i] > 100);
			cb(supply_low_fault, 1'b0);
			speed_err <= 16'sh0;
			frst();
		end
		give_verdict();
	end
endmodule // ecfm_top_tb
bind ecfm_top ecfm_assertions #(.WIN(WIN), .SOFT_MS(SOFT_MS)) chk_u (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwr_src(pwr_src), .aux_on(aux_on), .bus_present(bus_present),
	.phasing_done(phasing_done), .supply_low_fault(supply_low_fault),
	.fault_out(fault_out), .phase_valid(phase_valid), .enable_ok(enable_ok)
);
